// *** hdl/pwt_pkg.sv ***
// Constants, register map and field layout of the PWM timer unit
// Contract
// - Count clock cycles in a 32-bit counter behind a 32-bit prescaler.
// - Seven match registers feed six single-edge or three double-edge outputs.
// - The cycle match register sets the period and, in PWM mode, resets the counter.
// - Single-edge outputs rise at cycle match unless own match is zero, fall at own match.
// - Double-edge outputs rise and fall on two dedicated match registers.
// - Double-edge edges may sit at any count within the cycle.
// - Period and width are any whole number of timer counts.
// - In PWM mode new match values act only once released and in step with outputs.
// - Each match may keep counting, stop, or reset, and interrupt.
// - With PWM mode off the unit is a plain timer, outputs low.
// - Match flags enabled in the interrupt mask register combine into one interrupt request line.
package pwt_pkg;

   // Geometry
   localparam int          PWT_NUM_MATCH = 7;
   localparam int          PWT_NUM_OUT   = 6;
   localparam int          PWT_DW        = 32;
   localparam int          PWT_AW        = 8;

   // Register byte offsets
   localparam logic [7:0]  OFF_IR      = 8'h00;
   localparam logic [7:0]  OFF_TCR     = 8'h04;
   localparam logic [7:0]  OFF_TC      = 8'h08;
   localparam logic [7:0]  OFF_PR      = 8'h0c;
   localparam logic [7:0]  OFF_PC      = 8'h10;
   localparam logic [7:0]  OFF_MCR     = 8'h14;
   localparam logic [7:0]  OFF_CYC_MATCH = 8'h18;
   localparam logic [7:0]  OFF_MR_LAST = 8'h30;
   localparam logic [7:0]  OFF_PCR     = 8'h34;
   localparam logic [7:0]  OFF_LER     = 8'h38;
   localparam logic [7:0]  OFF_IMR     = 8'h3c;

   // Timer control bits
   localparam int          TCR_EN      = 0;
   localparam int          TCR_RST     = 1;
   localparam int          TCR_PWM     = 3;
   localparam logic [31:0] TCR_MASK    = 32'h0000000b;

   // Match control: three bits per match register
   localparam int          MCR_INT     = 0;
   localparam int          MCR_RESET   = 1;
   localparam int          MCR_STOP    = 2;
   localparam int          MCR_FLD     = 3;
   localparam logic [31:0] MCR_MASK    = 32'h001fffff;

   // Output control: bit k double-edge select, bit 8+k enable
   localparam int          PCR_OE_LSB  = 8;
   localparam logic [31:0] PCR_MASK    = 32'h00007e7c;

   // Reset values
   localparam logic [31:0] RST_WORD    = 32'h00000000;
   localparam logic [6:0]  RST_FLAGS   = 7'h00;
   localparam logic [5:0]  RST_OUT     = 6'h00;

endpackage

// *** hdl/pwt_unit.sv ***
// PWM timer unit: prescaled counter, seven matches, PWM outputs, Wishbone
`timescale 1ns/1ps
module pwt_unit
   import pwt_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Wishbone classic slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [PWT_AW-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [PWT_DW-1:0] wb_dat_i,
   output logic      [PWT_DW-1:0] wb_dat_o,
   output logic                   wb_ack_o,
   // Pins and interrupt
   output logic      [PWT_NUM_OUT-1:0] pwm_o,
   output logic                   irq_o
);

   // Byte-lane merge of a write
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // Decode of the match register window
   function automatic logic is_mr(input logic [7:0] adr);
      return (adr >= OFF_CYC_MATCH) && (adr <= OFF_MR_LAST)
             && (adr[1:0] == 2'h0);
   endfunction

   function automatic logic [2:0] mr_index(input logic [7:0] adr);
      logic [7:0] d;
      d = adr - OFF_CYC_MATCH;
      return d[4:2];
   endfunction

   // State
   logic [31:0] tc_r, tc_nxt;
   logic [31:0] pc_r, pc_nxt;
   logic [31:0] pr_r, pr_nxt;
   logic [31:0] tcr_r, tcr_nxt;
   logic [31:0] mcr_r, mcr_nxt;
   logic [31:0] pcr_r, pcr_nxt;
   logic [31:0] mr_sh_r  [PWT_NUM_MATCH];
   logic [31:0] mr_sh_nxt[PWT_NUM_MATCH];
   logic [31:0] mr_act_r [PWT_NUM_MATCH];
   logic [31:0] mr_act_nxt[PWT_NUM_MATCH];
   logic [6:0]  ir_r, ir_nxt;
   logic [6:0]  imr_r, imr_nxt;
   logic [6:0]  ler_r, ler_nxt;
   logic [5:0]  pwm_r, pwm_nxt;
   logic        irq_r, irq_nxt;
   logic        ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;

   // Events
   logic        hit_w;
   logic        wr_go_w;
   logic        run_w;
   logic        tick_w;
   logic        pwm_en_w;
   logic        reset_any_w;
   logic        stop_any_w;
   logic        cyc_start_w;
   logic [6:0]  match_w;

   // Match events, only on a counting tick so each count matches once
   always_comb begin
      hit_w    = wb_cyc_i & wb_stb_i;
      wr_go_w  = hit_w & wb_we_i & ack_r;
      pwm_en_w = tcr_r[TCR_PWM];
      run_w    = tcr_r[TCR_EN] & ~tcr_r[TCR_RST];
      tick_w   = run_w & (pc_r == pr_r);
      reset_any_w = 1'b0;
      stop_any_w  = 1'b0;
      for (int i = 0; i < PWT_NUM_MATCH; i++) begin
         match_w[i] = tick_w & (tc_r == mr_act_r[i]);
         if (match_w[i] & mcr_r[i*MCR_FLD + MCR_RESET]) begin
            reset_any_w = 1'b1;
         end
         if (match_w[i] & mcr_r[i*MCR_FLD + MCR_STOP]) begin
            stop_any_w = 1'b1;
         end
      end
      // PWM mode always wraps on the cycle match, whatever MCR says
      if (pwm_en_w & match_w[0]) begin
         reset_any_w = 1'b1;
      end
      cyc_start_w = pwm_en_w & match_w[0];
   end

   // Next state of counter, matches, outputs and registers
   always_comb begin
      tc_nxt  = tc_r;
      pc_nxt  = pc_r;
      pr_nxt  = pr_r;
      tcr_nxt = tcr_r;
      mcr_nxt = mcr_r;
      pcr_nxt = pcr_r;
      ir_nxt  = ir_r;
      imr_nxt = imr_r;
      ler_nxt = ler_r;
      pwm_nxt = pwm_r;
      dat_nxt = dat_r;
      ack_nxt = hit_w & ~ack_r;
      for (int i = 0; i < PWT_NUM_MATCH; i++) begin
         mr_sh_nxt[i]  = mr_sh_r[i];
         mr_act_nxt[i] = mr_act_r[i];
      end

      // Prescaler and counter
      if (tcr_r[TCR_RST]) begin
         tc_nxt = RST_WORD;
         pc_nxt = RST_WORD;
      end else if (run_w) begin
         if (tick_w) begin
            pc_nxt = RST_WORD;
            tc_nxt = reset_any_w ? RST_WORD : tc_r + 32'h1;
         end else begin
            pc_nxt = pc_r + 32'h1;
         end
      end
      if (stop_any_w) begin
         tcr_nxt[TCR_EN] = 1'b0;
      end

      // Released shadows load only at cycle start, so no pulse is torn
      if (cyc_start_w) begin
         for (int i = 0; i < PWT_NUM_MATCH; i++) begin
            if (ler_r[i]) begin
               mr_act_nxt[i] = mr_sh_r[i];
               ler_nxt[i]    = 1'b0;
            end
         end
      end

      // Output edges; a clear in the same tick as a set wins
      for (int k = 1; k <= PWT_NUM_OUT; k++) begin
         logic set_e;
         logic clr_e;
         set_e = 1'b0;
         clr_e = match_w[k];
         if (pcr_r[k] && k >= 2) begin
            set_e = match_w[k-1];
         end else begin
            // A zero edge count means constant low
            set_e = match_w[0] & (mr_act_r[k] != RST_WORD);
         end
         if (!pwm_en_w || !pcr_r[PCR_OE_LSB + k]) begin
            pwm_nxt[k-1] = 1'b0;
         end else if (clr_e) begin
            pwm_nxt[k-1] = 1'b0;
         end else if (set_e) begin
            pwm_nxt[k-1] = 1'b1;
         end
      end

      // Register reads, captured with the answer
      if (hit_w & ~ack_r) begin
         dat_nxt = RST_WORD;
         if (is_mr(wb_adr_i)) begin
            dat_nxt = mr_sh_r[mr_index(wb_adr_i)];
         end else begin
            case (wb_adr_i)
               OFF_IR:  dat_nxt[6:0] = ir_r;
               OFF_TCR: dat_nxt = tcr_r;
               OFF_TC:  dat_nxt = tc_r;
               OFF_PR:  dat_nxt = pr_r;
               OFF_PC:  dat_nxt = pc_r;
               OFF_MCR: dat_nxt = mcr_r;
               OFF_PCR: dat_nxt = pcr_r;
               OFF_LER: dat_nxt[6:0] = ler_r;
               OFF_IMR: dat_nxt[6:0] = imr_r;
               default: dat_nxt = RST_WORD;
            endcase
         end
      end

      // Register writes at the acknowledged edge; software overrides, except that a match still sets its IR flag
      if (wr_go_w) begin
         if (is_mr(wb_adr_i)) begin
            mr_sh_nxt[mr_index(wb_adr_i)] =
               lane_merge(mr_sh_r[mr_index(wb_adr_i)], wb_dat_i, wb_sel_i);
            // A plain timer takes new match values at once
            if (!pwm_en_w) begin
               mr_act_nxt[mr_index(wb_adr_i)] =
                  mr_sh_nxt[mr_index(wb_adr_i)];
            end
         end else begin
            case (wb_adr_i)
               OFF_IR:  ir_nxt = ir_r & ~(wb_dat_i[6:0] & {7{wb_sel_i[0]}});
               OFF_TCR: tcr_nxt = lane_merge(tcr_r, wb_dat_i, wb_sel_i)
                                  & TCR_MASK;
               OFF_TC:  tc_nxt  = lane_merge(tc_r, wb_dat_i, wb_sel_i);
               OFF_PR:  pr_nxt  = lane_merge(pr_r, wb_dat_i, wb_sel_i);
               OFF_PC:  pc_nxt  = lane_merge(pc_r, wb_dat_i, wb_sel_i);
               OFF_MCR: mcr_nxt = lane_merge(mcr_r, wb_dat_i, wb_sel_i)
                                  & MCR_MASK;
               OFF_PCR: pcr_nxt = lane_merge(pcr_r, wb_dat_i, wb_sel_i)
                                  & PCR_MASK;
               OFF_LER: begin
                  if (wb_sel_i[0]) begin
                     ler_nxt = ler_nxt | wb_dat_i[6:0];
                  end
               end
               OFF_IMR: begin
                  if (wb_sel_i[0]) begin
                     imr_nxt = wb_dat_i[6:0];
                  end
               end
               default: ;
            endcase
         end
      end

      // Sticky flags: a match in the clearing cycle still sets
      for (int i = 0; i < PWT_NUM_MATCH; i++) begin
         if (match_w[i] & mcr_r[i*MCR_FLD + MCR_INT]) begin
            ir_nxt[i] = 1'b1;
         end
      end
      irq_nxt = |(ir_nxt & imr_nxt);
   end

   // Register all state
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tc_r  <= RST_WORD;
         pc_r  <= RST_WORD;
         pr_r  <= RST_WORD;
         tcr_r <= RST_WORD;
         mcr_r <= RST_WORD;
         pcr_r <= RST_WORD;
         ir_r  <= RST_FLAGS;
         imr_r <= RST_FLAGS;
         ler_r <= RST_FLAGS;
         pwm_r <= RST_OUT;
         irq_r <= 1'b0;
         ack_r <= 1'b0;
         dat_r <= RST_WORD;
         for (int i = 0; i < PWT_NUM_MATCH; i++) begin
            mr_sh_r[i]  <= RST_WORD;
            mr_act_r[i] <= RST_WORD;
         end
      end else begin
         tc_r  <= tc_nxt;
         pc_r  <= pc_nxt;
         pr_r  <= pr_nxt;
         tcr_r <= tcr_nxt;
         mcr_r <= mcr_nxt;
         pcr_r <= pcr_nxt;
         ir_r  <= ir_nxt;
         imr_r <= imr_nxt;
         ler_r <= ler_nxt;
         pwm_r <= pwm_nxt;
         irq_r <= irq_nxt;
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         for (int i = 0; i < PWT_NUM_MATCH; i++) begin
            mr_sh_r[i]  <= mr_sh_nxt[i];
            mr_act_r[i] <= mr_act_nxt[i];
         end
      end
   end

   // Outputs straight from flops
   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign pwm_o    = pwm_r;
   assign irq_o    = irq_r;

   // Checks
   sequence s_cycle_start;
      pwm_en_w && match_w[0] && !wr_go_w;
   endsequence

   sequence s_tick_plain;
      tick_w && !reset_any_w && !wr_go_w;
   endsequence

   AST_PC_WRAP: assert property (@(posedge clk) disable iff (!resetn)
      tick_w && !wr_go_w |=> pc_r == 32'h0)
      else $error("prescaler did not clear on tick");

   AST_TC_STEP: assert property (@(posedge clk) disable iff (!resetn)
      s_tick_plain |=> tc_r == $past(tc_r) + 32'h1)
      else $error("counter did not step on tick");

   AST_CYCLE_WRAP: assert property (@(posedge clk)
      disable iff (!resetn) s_cycle_start |=> tc_r == 32'h0)
      else $error("cycle match did not reset counter");

   AST_STOP: assert property (@(posedge clk) disable iff (!resetn)
      stop_any_w && !wr_go_w |=> !tcr_r[TCR_EN])
      else $error("stop on match did not stop");

   AST_SE_RISE: assert property (@(posedge clk) disable iff (!resetn)
      s_cycle_start and (pcr_r[PCR_OE_LSB + 1] && mr_act_r[1] != 32'h0
      && !match_w[1]) |=> pwm_r[0])
      else $error("single-edge output missed rise");

   AST_SE_FALL: assert property (@(posedge clk) disable iff (!resetn)
      pwm_en_w && match_w[1] |=> !pwm_r[0])
      else $error("output did not fall at own match");

   AST_DE_RISE: assert property (@(posedge clk) disable iff (!resetn)
      pwm_en_w && pcr_r[2] && pcr_r[PCR_OE_LSB + 2] && match_w[1]
      && !match_w[2] |=> pwm_r[1])
      else $error("double-edge output missed rise");

   AST_HOLD_ACT: assert property (@(posedge clk) disable iff (!resetn)
      pwm_en_w && !match_w[0] |=> $stable(mr_act_r[1]))
      else $error("match value changed mid cycle");

   AST_LATCH: assert property (@(posedge clk) disable iff (!resetn)
      s_cycle_start and (ler_r[1]) |=> mr_act_r[1] == $past(mr_sh_r[1]))
      else $error("released value not loaded at cycle start");

   AST_TIMER_QUIET: assert property (@(posedge clk)
      disable iff (!resetn) !pwm_en_w |=> pwm_r == 6'h00)
      else $error("output active outside PWM mode");

   AST_IRQ: assert property (@(posedge clk) disable iff (!resetn)
      irq_r == |(ir_r & imr_r))
      else $error("interrupt line disagrees with flags");

   AST_ACK: assert property (@(posedge clk) disable iff (!resetn)
      hit_w && !ack_r |=> ack_r ##1 !ack_r)
      else $error("bus answer not a single cycle");

endmodule

// *** verification/pwt_load_model.sv ***
// Load model on the PWM pins: measures pulse width and period
`timescale 1ns/1ps
module pwt_load_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Pins driven by the unit
   input  wire logic [5:0] pwm_o,
   // Measurements: lengths in clocks, and a count of rises
   output logic [5:0][7:0] hi_len,
   output logic [5:0][7:0] per_len,
   output logic [5:0][7:0] rises
);
   logic [7:0] cnt [6];
   logic [5:0] prev;

   // A pure load: it only watches, so a rise restarts the period count
   always_ff @(posedge clk) begin
      prev <= resetn ? pwm_o : 6'h00;
      for (int k = 0; k < 6; k++) begin
         cnt[k] <= (pwm_o[k] && !prev[k]) ? 8'h01 : cnt[k] + 8'h01;
         if (!resetn) begin
            rises[k] <= 8'h00;
         end else if (pwm_o[k] && !prev[k]) begin
            per_len[k] <= cnt[k];
            rises[k]   <= rises[k] + 8'h01;
         end
         if (!pwm_o[k] && prev[k])
            hi_len[k] <= cnt[k];
      end
   end
endmodule

// *** verification/tb.sv ***
// Self-checking testbench of the PWM timer unit
`timescale 1ns/1ps
module tb;
   import pwt_pkg::*;
   typedef struct packed {
      logic [31:0] pr, cyc, mr1, mr2, pcr;
      logic [2:0]  ch;
      logic [7:0]  hi, per;
   } pwt_row_t;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        wb_cyc = 1'b0;
   logic        wb_stb = 1'b0;
   logic        wb_we = 1'b0;
   logic [7:0]  wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [3:0]  wb_sel = 4'hf;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic [5:0]  pwm_o;
   logic        irq_o;
   logic [5:0][7:0] hi_len;
   logic [5:0][7:0] per_len;
   logic [5:0][7:0] rises;
   logic [31:0] q;
   logic [7:0]  s0;
   int          errors = 0;
   int          samples_checked = 0;
   // Single edge on output 1, then double edge on output 2
   localparam pwt_row_t ROWS [6] = '{
      '{32'h0, 32'h3, 32'h1, 32'h0, 32'h200, 3'h0, 8'h02, 8'h04},
      '{32'h0, 32'h9, 32'h7, 32'h0, 32'h200, 3'h0, 8'h08, 8'h0a},
      '{32'h1, 32'h3, 32'h1, 32'h0, 32'h200, 3'h0, 8'h04, 8'h08},
      '{32'h0, 32'h4, 32'h1, 32'h3, 32'h404, 3'h1, 8'h02, 8'h05},
      '{32'h0, 32'h4, 32'h3, 32'h1, 32'h404, 3'h1, 8'h03, 8'h05},
      '{32'h0, 32'h4, 32'h0, 32'h4, 32'h404, 3'h1, 8'h04, 8'h05}};

   // 20 MHz clock
   always #25 clk = ~clk;

   pwt_unit pwt_unit_inst (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc),
      .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pwm_o(pwm_o), .irq_o(irq_o));
   pwt_load_model pwt_load_model_inst (.clk(clk), .resetn(resetn),
      .pwm_o(pwm_o), .hi_len(hi_len), .per_len(per_len), .rises(rises));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled, then one idle
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we  <= w;
      wb_adr <= a;
      wb_dat <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         errors++;
         stop_test();
      end
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   // Bounded wait for a number of new rising edges on one pin
   task automatic wait_rises(input int ch, input int num);
      logic [7:0] s;
      int n;
      s = rises[ch];
      n = 0;
      while (int'(8'(rises[ch] - s)) < num && n < 400) begin
         @(posedge clk);
         n++;
      end
      if (int'(8'(rises[ch] - s)) < num) begin
         errors++;
         stop_test();
      end
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // Reset values, plus one unmapped word at 0x40
      for (int a = 0; a <= 16; a++)
         rd(8'(a * 4), 32'h0);
      wr(8'h40, 32'hffffffff);
      rd(8'h40, 32'h0);
      wr(OFF_PR, 32'hffffffff);
      rd(OFF_PR, 32'hffffffff);
      // Byte lanes: only the two low bytes of the prescale change
      wb_sel <= 4'h3;
      wr(OFF_PR, 32'h12345678);
      wb_sel <= 4'hf;
      rd(OFF_PR, 32'hffff5678);
      for (int i = 0; i < 7; i++) begin
         wr(OFF_CYC_MATCH + 8'(i * 4), 32'ha5a50000 + 32'(i));
         rd(OFF_CYC_MATCH + 8'(i * 4), 32'ha5a50000 + 32'(i));
      end
      $display("test registers done");
      // Waveform table
      for (int i = 0; i < 6; i++) begin
         wr(OFF_TCR, 32'h2);
         wr(OFF_PR, ROWS[i].pr);
         wr(OFF_CYC_MATCH, ROWS[i].cyc);
         wr(OFF_CYC_MATCH + 8'h04, ROWS[i].mr1);
         wr(OFF_CYC_MATCH + 8'h08, ROWS[i].mr2);
         wr(OFF_PCR, ROWS[i].pcr);
         wr(OFF_TCR, 32'h9);
         wait_rises(int'(ROWS[i].ch), 3);
         chk(32'(hi_len[ROWS[i].ch]), 32'(ROWS[i].hi));
         chk(32'(per_len[ROWS[i].ch]), 32'(ROWS[i].per));
      end
      $display("test waveforms done");
      // Shadow value waits for release, then loads at the cycle start
      wr(OFF_CYC_MATCH + 8'h08, 32'h2);
      wait_rises(1, 3);
      chk(32'(hi_len[1]), 32'h4);
      rd(OFF_CYC_MATCH + 8'h08, 32'h2);
      wr(OFF_LER, 32'h4);
      wait_rises(1, 3);
      chk(32'(hi_len[1]), 32'h2);
      rd(OFF_LER, 32'h0);
      $display("test release done");
      // Zero match keeps a single-edge output low
      wr(OFF_TCR, 32'h2);
      wr(OFF_CYC_MATCH, 32'h3);
      wr(OFF_CYC_MATCH + 8'h04, 32'h0);
      wr(OFF_PCR, 32'h600);
      s0 = rises[0];
      wr(OFF_TCR, 32'h9);
      wait_rises(1, 3);
      chk(32'(rises[0]), 32'(s0));
      chk(32'(pwm_o[0]), 32'h0);
      $display("test constant low done");
      // Plain timer: stop and interrupt on match 3
      wr(OFF_TCR, 32'h2);
      wr(OFF_CYC_MATCH + 8'h0c, 32'h5);
      wr(OFF_MCR, 32'ha00);
      wr(OFF_IMR, 32'h8);
      wr(OFF_PCR, 32'h7e00);
      wr(OFF_TCR, 32'h1);
      for (int n = 0; n < 50 && irq_o !== 1'b1; n++)
         @(posedge clk);
      // The match never came: count it and close the run
      if (irq_o !== 1'b1) begin
         errors++;
         stop_test();
      end
      chk(32'(pwm_o), 32'h0);
      rd(OFF_TC, 32'h6);
      rd(OFF_TCR, 32'h0);
      rd(OFF_IR, 32'h8);
      chk(32'(irq_o), 32'h1);
      wr(OFF_IMR, 32'h0);
      chk(32'(irq_o), 32'h0);
      wr(OFF_IMR, 32'h8);
      chk(32'(irq_o), 32'h1);
      wr(OFF_IR, 32'h8);
      chk(32'(irq_o), 32'h0);
      rd(OFF_IR, 32'h0);
      $display("test timer done");
      // Reset on match 3 keeps the count at or below 5
      wr(OFF_MCR, 32'h400);
      wr(OFF_TC, 32'h0);
      wr(OFF_TCR, 32'h1);
      for (int n = 0; n < 6; n++) begin
         wb(1'b0, OFF_TC, 32'h0);
         chk(32'(q <= 32'h5), 32'h1);
      end
      $display("test reset on match done");
      // Second reset while running, with outputs and interrupt up
      wr(OFF_TCR, 32'h2);
      wr(OFF_MCR, 32'h1);
      wr(OFF_IMR, 32'h1);
      wr(OFF_TCR, 32'h9);
      wait_rises(2, 1);
      chk(32'(pwm_o[2]), 32'h1);
      chk(32'(irq_o), 32'h1);
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(pwm_o), 32'h0);
      chk(32'(irq_o), 32'h0);
      resetn <= 1'b1;
      @(posedge clk);
      rd(OFF_TCR, 32'h0);
      rd(OFF_TC, 32'h0);
      $display("test second reset done");
      stop_test();
   end
endmodule
